// ### design/rsc_pkg.sv
// ----------------------------------------
// shared constants for regulator start-up
// ----------------------------------------
package rsc_pkg;

  // clock rate
  localparam int CLK_MHZ = 125;

  // soft-start ramp lengths in microseconds
  localparam int SS_US_0 = 500;
  localparam int SS_US_1 = 1000;
  localparam int SS_US_2 = 2000;
  localparam int SS_US_3 = 4000;
  localparam int SS_CYC_0 = SS_US_0 * CLK_MHZ;
  localparam int SS_CYC_1 = SS_US_1 * CLK_MHZ;
  localparam int SS_CYC_2 = SS_US_2 * CLK_MHZ;
  localparam int SS_CYC_3 = SS_US_3 * CLK_MHZ;

  // slew step periods in nanoseconds, rounded down to cycles
  localparam int SLEW_NS_0 = 500;
  localparam int SLEW_NS_1 = 1000;
  localparam int SLEW_NS_2 = 5000;
  localparam int SLEW_NS_3 = 10000;
  localparam int SLEW_CYC_0 = SLEW_NS_0 * CLK_MHZ / 1000;
  localparam int SLEW_CYC_1 = SLEW_NS_1 * CLK_MHZ / 1000;
  localparam int SLEW_CYC_2 = SLEW_NS_2 * CLK_MHZ / 1000;
  localparam int SLEW_CYC_3 = SLEW_NS_3 * CLK_MHZ / 1000;

  // reference settle, strap settle and enable-to-ramp delay
  localparam int REF_SETTLE_NS = 1000;
  localparam int REF_SETTLE_CYC = REF_SETTLE_NS * CLK_MHZ / 1000;
  localparam int STRAP_SETTLE_NS = 2000;
  localparam int STRAP_SETTLE_CYC = STRAP_SETTLE_NS * CLK_MHZ / 1000;
  localparam int START_DELAY_US = 20;
  localparam int START_DELAY_CYC = START_DELAY_US * CLK_MHZ;

  // strap codes: msb then lsb
  localparam logic [1:0] STRAP_GND_SHORT = 2'h0;
  localparam logic [1:0] STRAP_GND_RES = 2'h1;
  localparam logic [1:0] STRAP_VIN_RES = 2'h2;
  localparam logic [1:0] STRAP_VIN_SHORT = 2'h3;

  // reset values
  localparam logic [1:0] RAMP_RST = 2'h1;
  localparam logic [1:0] SPAN_RST = 2'h2;
  localparam logic [1:0] SLEW_RST = 2'h0;
  localparam logic [7:0] SET_GND_SHORT = 8'h46;
  localparam logic [7:0] SET_VIN_SHORT = 8'h5F;

  // output level in microvolts from span and setpoint code
  function automatic logic [21:0] setpoint_uv(input logic [1:0] span, input logic [7:0] code);
    int step;
    int base;
    step = 10000;
    base = 800000;
    case (span)
      2'h0: step = 1250;
      2'h1: step = 2500;
      2'h2: step = 5000;
      default: step = 10000;
    endcase
    if (span != 2'h3)
      base = 400000;
    return 22'(base + int'(code) * step);
  endfunction : setpoint_uv

  // switching frequency in kHz from the frequency strap
  function automatic logic [11:0] freq_khz(input logic [1:0] strap);
    case (strap)
      STRAP_GND_SHORT: return 12'h5DC;
      STRAP_GND_RES: return 12'h8CA;
      STRAP_VIN_RES: return 12'h9C4;
      default: return 12'hBB8;
    endcase
  endfunction : freq_khz

endpackage : rsc_pkg

// ### design/rsc_sync2.sv
`timescale 1ns/1ps
// ----------------------------------------
// two flip-flop level synchroniser
// ----------------------------------------
module rsc_sync2 (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // level in and out
  input wire logic din,
  output logic dout
);
  logic meta_reg; // first stage, read only by the second

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_reg <= 1'b0;
      dout <= 1'b0;
    end
    else
    begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end
endmodule : rsc_sync2

// ### design/rsc_strap_decoder.sv
`timescale 1ns/1ps
// ----------------------------------------
// two-step resistor strap decoder
// ----------------------------------------
module rsc_strap_decoder (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // control: start is a level held until done
  input wire logic start,
  output logic done,
  output logic [1:0] code,
  // strap pin and bias switches
  input wire logic strap_pin,
  output logic first_bias_switch,
  output logic second_bias_switch
);
  typedef enum logic [1:0] {DEC_IDLE, DEC_MSB, DEC_LSB, DEC_DONE} rsc_dec_state_e;

  rsc_dec_state_e state_reg, state_next; // decoder phase
  logic [8:0] cnt_reg, cnt_next; // settle counter
  logic [1:0] code_reg, code_next; // decoded bits
  logic sw1_reg, sw1_next; // first switch closed
  logic sw2_reg, sw2_next; // second switch closed
  logic pin_s; // synchronised pin level

  // pin passes two flops before the decoder looks at it
  rsc_sync2 u_sync (
    .clk(clk),
    .resetn(resetn),
    .din(strap_pin),
    .dout(pin_s)
  );

  // settle wait covers the sync latency as well as the pin rc
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    code_next = code_reg;
    sw1_next = sw1_reg;
    sw2_next = sw2_reg;
    case (state_reg)
      DEC_IDLE:
        if (start)
        begin
          state_next = DEC_MSB;
          cnt_next = 9'h000;
          sw1_next = 1'b0;
          sw2_next = 1'b0;
        end
      DEC_MSB:
        if (cnt_reg == 9'(rsc_pkg::STRAP_SETTLE_CYC - 1))
        begin
          code_next[1] = pin_s;
          sw1_next = !pin_s;
          sw2_next = pin_s;
          cnt_next = 9'h000;
          state_next = DEC_LSB;
        end
        else
          cnt_next = cnt_reg + 9'h001;
      DEC_LSB:
        if (cnt_reg == 9'(rsc_pkg::STRAP_SETTLE_CYC - 1))
        begin
          code_next[0] = pin_s;
          sw1_next = 1'b0;
          sw2_next = 1'b0;
          state_next = DEC_DONE;
        end
        else
          cnt_next = cnt_reg + 9'h001;
      default:
        if (!start)
          state_next = DEC_IDLE;
    endcase
  end

  // register the decoder state
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= DEC_IDLE;
      cnt_reg <= 9'h000;
      code_reg <= 2'h0;
      sw1_reg <= 1'b0;
      sw2_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      code_reg <= code_next;
      sw1_reg <= sw1_next;
      sw2_reg <= sw2_next;
    end
  end

  assign done = (state_reg == DEC_DONE);
  assign code = code_reg;
  assign first_bias_switch = sw1_reg;
  assign second_bias_switch = sw2_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  msb_open_a: assert property (@(posedge clk) disable iff (!resetn)
    (state_reg == DEC_MSB) |-> (!sw1_reg && !sw2_reg))
    else $error("bias switch closed during msb sample");
  lsb_switch_a: assert property (@(posedge clk) disable iff (!resetn)
    (state_reg == DEC_LSB) |-> (sw1_reg == !code_reg[1]) && (sw2_reg == code_reg[1]))
    else $error("wrong bias switch for lsb sample");
endmodule : rsc_strap_decoder

// ### design/rsc_startup_ctrl.sv
`timescale 1ns/1ps
// Contract
// - on supply, hold enable, reference, read straps
// - after init, open host access, release enable
// - enable low: converter idle, registers usable
// - enable high: short delay, then ramp
// - ramp code picks four lengths, 1ms default
// - changes after soft-start begins wait for end
// - finish captured setpoint, then ramp to new
// - force discontinuous conduction during start ramp
// - frequency strap sets switching frequency
// - msb sampled with both switches open
// - msb zero: first switch, high gives one
// - msb one: second switch, low gives zero
// - voltage strap uses same decoder
// - level is base plus code times step
// - span defaults to 0.4V-1.675V, 5mV
// - new span applies after next setpoint write
// - voltage strap loads default setpoint code
// - voltage strap also picks target address
// - writes while disabled apply at next enable
// - start-up ramps to the setpoint held when the delay ends
// - preprogrammed setpoint used directly at start
// - changes during any ramp wait for end
// - fault pulls enable low unless standalone
// - enable toggling never reloads registers
module rsc_startup_ctrl #(
  parameter int SS_CYC_0 = rsc_pkg::SS_CYC_0, // 500us soft start
  parameter int SS_CYC_1 = rsc_pkg::SS_CYC_1, // 1ms soft start
  parameter int SS_CYC_2 = rsc_pkg::SS_CYC_2, // 2ms soft start
  parameter int SS_CYC_3 = rsc_pkg::SS_CYC_3, // 4ms soft start
  parameter logic [7:0] SET_GND_RES = 8'h50, // variant dependent default
  parameter logic [7:0] SET_VIN_RES = 8'h50 // variant dependent default
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // supply and fault status, asynchronous
  input wire logic supply_ok,
  input wire logic fault_present,
  input wire logic standalone_bit,
  // open-drain enable pin
  input wire logic enable_in,
  output logic enable_out,
  output logic enable_oe,
  // strap pins and bias switches
  input wire logic voltage_strap,
  output logic voltage_first_bias_switch,
  output logic voltage_second_bias_switch,
  input wire logic frequency_strap,
  output logic frequency_first_bias_switch,
  output logic frequency_second_bias_switch,
  input wire logic clock_out_strap,
  // host register writes, one-cycle strobes
  input wire logic wr_setpoint,
  input wire logic wr_span,
  input wire logic wr_ramp,
  input wire logic wr_slew,
  input wire logic [7:0] wr_data,
  // host register reads
  output logic host_access_en,
  output logic [7:0] setpoint_code,
  output logic [1:0] output_span_code,
  output logic [1:0] ramp_duration_code,
  output logic [1:0] slew_code,
  // strap results
  output logic [1:0] freq_sel_code,
  output logic [11:0] freq_khz,
  output logic [1:0] target_addr_code,
  output logic clock_out_sel,
  // converter control
  output logic reference_en,
  output logic converter_run,
  output logic dcm_force,
  output logic soft_start_active,
  output logic ramp_active,
  output logic [7:0] target_level_code,
  output logic [1:0] active_span_code,
  output logic [21:0] target_uv
);
  typedef enum logic [2:0] {INIT_OFF, INIT_REF, INIT_STRAP, INIT_LOAD, INIT_DONE} rsc_init_e;
  typedef enum logic [2:0] {CV_IDLE, CV_DELAY, CV_SOFT, CV_DVS, CV_RUN} rsc_conv_e;

  // ----------------------------------------
  // synchronised inputs
  // ----------------------------------------
  logic supply_s; // supply above lockout
  logic fault_s; // fault condition
  logic enable_s; // enable pin level
  logic clkout_s; // clock-out strap level

  rsc_sync2 u_sync_supply (.clk(clk), .resetn(resetn), .din(supply_ok), .dout(supply_s));
  rsc_sync2 u_sync_fault (.clk(clk), .resetn(resetn), .din(fault_present), .dout(fault_s));
  rsc_sync2 u_sync_en (.clk(clk), .resetn(resetn), .din(enable_in), .dout(enable_s));
  rsc_sync2 u_sync_clkout (.clk(clk), .resetn(resetn), .din(clock_out_strap), .dout(clkout_s));

  // ----------------------------------------
  // strap decoders
  // ----------------------------------------
  rsc_init_e init_reg, init_next; // power-up sequence
  logic [7:0] icnt_reg, icnt_next; // reference settle counter
  logic v_done, f_done; // decoders finished
  logic [1:0] v_code, f_code; // decoded straps
  logic strap_go; // decoders run while this is high

  assign strap_go = (init_reg == INIT_STRAP);

  // voltage strap uses the same two-step decoder as frequency
  rsc_strap_decoder u_vdec (
    .clk(clk),
    .resetn(resetn),
    .start(strap_go),
    .done(v_done),
    .code(v_code),
    .strap_pin(voltage_strap),
    .first_bias_switch(voltage_first_bias_switch),
    .second_bias_switch(voltage_second_bias_switch)
  );
  rsc_strap_decoder u_fdec (
    .clk(clk),
    .resetn(resetn),
    .start(strap_go),
    .done(f_done),
    .code(f_code),
    .strap_pin(frequency_strap),
    .first_bias_switch(frequency_first_bias_switch),
    .second_bias_switch(frequency_second_bias_switch)
  );

  // ----------------------------------------
  // power-up sequence
  // ----------------------------------------
  // loss of supply restarts from scratch; enable never does
  always_comb
  begin
    init_next = init_reg;
    icnt_next = icnt_reg;
    case (init_reg)
      INIT_OFF:
        if (supply_s)
        begin
          init_next = INIT_REF;
          icnt_next = 8'h00;
        end
      INIT_REF:
        if (icnt_reg == 8'(rsc_pkg::REF_SETTLE_CYC - 1))
          init_next = INIT_STRAP;
        else
          icnt_next = icnt_reg + 8'h01;
      INIT_STRAP:
        if (v_done && f_done)
          init_next = INIT_LOAD;
      INIT_LOAD:
        init_next = INIT_DONE;
      default:
        init_next = INIT_DONE;
    endcase
    if (!supply_s)
      init_next = INIT_OFF;
  end

  // register the sequence state
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      init_reg <= INIT_OFF;
      icnt_reg <= 8'h00;
    end
    else
    begin
      init_reg <= init_next;
      icnt_reg <= icnt_next;
    end
  end

  logic init_done; // sequence finished
  assign init_done = (init_reg == INIT_DONE);
  assign host_access_en = init_done;
  assign reference_en = (init_reg != INIT_OFF);
  // pulled low until init ends, and on fault unless standalone
  assign enable_out = 1'b0;
  assign enable_oe = !init_done || (fault_s && !standalone_bit);

  // ----------------------------------------
  // host registers and strap results
  // ----------------------------------------
  logic [7:0] set_reg, set_next; // setpoint code
  logic [1:0] span_reg, span_next; // written span
  logic [1:0] span_eff_reg, span_eff_next; // span armed by setpoint write
  logic [1:0] ramp_reg, ramp_next; // soft-start length code
  logic [1:0] slew_reg, slew_next; // slew code
  logic [1:0] frequency_strap_reg, frequency_strap_next; // frequency strap code
  logic [1:0] addr_reg, addr_next; // voltage strap code
  logic clko_reg, clko_next; // clock-out strap

  // registers take writes once init is done; the converter decides when to use them
  always_comb
  begin
    set_next = set_reg;
    span_next = span_reg;
    span_eff_next = span_eff_reg;
    ramp_next = ramp_reg;
    slew_next = slew_reg;
    frequency_strap_next = frequency_strap_reg;
    addr_next = addr_reg;
    clko_next = clko_reg;
    if (init_reg == INIT_LOAD)
    begin
      frequency_strap_next = f_code;
      addr_next = v_code;
      clko_next = clkout_s;
      span_next = rsc_pkg::SPAN_RST;
      span_eff_next = rsc_pkg::SPAN_RST;
      ramp_next = rsc_pkg::RAMP_RST;
      slew_next = rsc_pkg::SLEW_RST;
      case (v_code)
        rsc_pkg::STRAP_GND_SHORT: set_next = rsc_pkg::SET_GND_SHORT;
        rsc_pkg::STRAP_GND_RES: set_next = SET_GND_RES;
        rsc_pkg::STRAP_VIN_RES: set_next = SET_VIN_RES;
        default: set_next = rsc_pkg::SET_VIN_SHORT;
      endcase
    end
    else if (init_done)
    begin
      if (wr_setpoint)
      begin
        set_next = wr_data;
        span_eff_next = wr_span ? wr_data[1:0] : span_reg;
      end
      if (wr_span)
        span_next = wr_data[1:0];
      if (wr_ramp)
        ramp_next = wr_data[1:0];
      if (wr_slew)
        slew_next = wr_data[1:0];
    end
  end

  // register the host settings
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      set_reg <= 8'h00;
      span_reg <= rsc_pkg::SPAN_RST;
      span_eff_reg <= rsc_pkg::SPAN_RST;
      ramp_reg <= rsc_pkg::RAMP_RST;
      slew_reg <= rsc_pkg::SLEW_RST;
      frequency_strap_reg <= 2'h0;
      addr_reg <= 2'h0;
      clko_reg <= 1'b0;
    end
    else
    begin
      set_reg <= set_next;
      span_reg <= span_next;
      span_eff_reg <= span_eff_next;
      ramp_reg <= ramp_next;
      slew_reg <= slew_next;
      frequency_strap_reg <= frequency_strap_next;
      addr_reg <= addr_next;
      clko_reg <= clko_next;
    end
  end

  assign setpoint_code = set_reg;
  assign output_span_code = span_reg;
  assign ramp_duration_code = ramp_reg;
  assign slew_code = slew_reg;
  assign freq_sel_code = frequency_strap_reg;
  assign target_addr_code = addr_reg;
  assign clock_out_sel = clko_reg;

  // ----------------------------------------
  // converter start and voltage ramps
  // ----------------------------------------
  rsc_conv_e cv_reg, cv_next; // converter phase
  logic [19:0] cnt_reg, cnt_next; // delay, soft-start and slew timer
  logic [7:0] act_reg, act_next; // level now driven
  logic [7:0] tgt_reg, tgt_next; // level a ramp heads for
  logic [1:0] aspan_reg, aspan_next; // span in use
  logic [1:0] aramp_reg, aramp_next; // soft-start length in use
  logic [1:0] aslew_reg, aslew_next; // slew in use
  logic [21:0] uv_reg, uv_next; // level in microvolts
  logic [11:0] fk_reg, fk_next; // frequency in kHz
  logic run_ok; // enable high, init done, no fault
  logic pending; // setpoint or armed span differs from the one in use
  logic [19:0] ss_last; // last soft-start count
  logic [19:0] slew_last; // last slew step count

  assign run_ok = init_done && enable_s && !fault_s;
  assign pending = (set_reg != act_reg) || (span_eff_reg != aspan_reg);

  // soft-start length, codes ascending from the shortest
  always_comb
  begin
    case (aramp_reg)
      2'h0: ss_last = 20'(SS_CYC_0 - 1);
      2'h1: ss_last = 20'(SS_CYC_1 - 1);
      2'h2: ss_last = 20'(SS_CYC_2 - 1);
      default: ss_last = 20'(SS_CYC_3 - 1);
    endcase
    case (aslew_reg)
      2'h0: slew_last = 20'(rsc_pkg::SLEW_CYC_0 - 1);
      2'h1: slew_last = 20'(rsc_pkg::SLEW_CYC_1 - 1);
      2'h2: slew_last = 20'(rsc_pkg::SLEW_CYC_2 - 1);
      default: slew_last = 20'(rsc_pkg::SLEW_CYC_3 - 1);
    endcase
  end

  // settings are latched at phase entry; later writes wait their turn
  always_comb
  begin
    cv_next = cv_reg;
    cnt_next = cnt_reg + 20'h00001;
    act_next = act_reg;
    tgt_next = tgt_reg;
    aspan_next = aspan_reg;
    aramp_next = aramp_reg;
    aslew_next = aslew_reg;
    case (cv_reg)
      CV_IDLE:
      begin
        cnt_next = 20'h00000;
        if (run_ok)
          cv_next = CV_DELAY;
      end
      CV_DELAY:
        if (cnt_reg == 20'(rsc_pkg::START_DELAY_CYC - 1))
        begin
          cv_next = CV_SOFT;
          cnt_next = 20'h00000;
          act_next = set_reg;
          aspan_next = span_eff_reg;
          aramp_next = ramp_reg;
        end
      CV_SOFT:
        if (cnt_reg == ss_last)
        begin
          cv_next = pending ? CV_DVS : CV_RUN;
          cnt_next = 20'h00000;
          tgt_next = set_reg;
          aspan_next = span_eff_reg;
          aslew_next = slew_reg;
        end
      CV_DVS:
        if (act_reg == tgt_reg)
          cv_next = CV_RUN;
        else if (cnt_reg == slew_last)
        begin
          cnt_next = 20'h00000;
          act_next = (tgt_reg > act_reg) ? act_reg + 8'h01 : act_reg - 8'h01;
        end
      default:
        if (pending)
        begin
          cv_next = CV_DVS;
          cnt_next = 20'h00000;
          tgt_next = set_reg;
          aspan_next = span_eff_reg;
          aslew_next = slew_reg;
        end
    endcase
    if (!run_ok)
      cv_next = CV_IDLE;
    uv_next = rsc_pkg::setpoint_uv(aspan_reg, act_reg);
    fk_next = rsc_pkg::freq_khz(frequency_strap_reg);
  end

  // register the converter state
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cv_reg <= CV_IDLE;
      cnt_reg <= 20'h00000;
      act_reg <= 8'h00;
      tgt_reg <= 8'h00;
      aspan_reg <= rsc_pkg::SPAN_RST;
      aramp_reg <= rsc_pkg::RAMP_RST;
      aslew_reg <= rsc_pkg::SLEW_RST;
      uv_reg <= 22'h000000;
      fk_reg <= 12'h000;
    end
    else
    begin
      cv_reg <= cv_next;
      cnt_reg <= cnt_next;
      act_reg <= act_next;
      tgt_reg <= tgt_next;
      aspan_reg <= aspan_next;
      aramp_reg <= aramp_next;
      aslew_reg <= aslew_next;
      uv_reg <= uv_next;
      fk_reg <= fk_next;
    end
  end

  assign converter_run = (cv_reg == CV_SOFT) || (cv_reg == CV_DVS) || (cv_reg == CV_RUN);
  assign soft_start_active = (cv_reg == CV_SOFT);
  assign dcm_force = (cv_reg == CV_SOFT);
  assign ramp_active = (cv_reg == CV_SOFT) || (cv_reg == CV_DVS);
  assign target_level_code = act_reg;
  assign active_span_code = aspan_reg;
  assign target_uv = uv_reg;
  assign freq_khz = fk_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  init_hold_a: assert property (!supply_s |=> enable_oe && !host_access_en)
    else $error("enable released without supply");
  host_open_a: assert property ($rose(host_access_en) |-> $past(init_reg) == INIT_LOAD)
    else $error("host access opened before defaults loaded");
  idle_low_a: assert property (init_done && !enable_s |=> !converter_run)
    else $error("converter runs with enable low");
  start_delay_a: assert property ($rose(soft_start_active) |-> $past(cv_reg) == CV_DELAY)
    else $error("soft start without delay");
  soft_hold_a: assert property (soft_start_active && $past(soft_start_active) |-> $stable(act_reg))
    else $error("level changed during soft start");
  dcm_ramp_a: assert property (soft_start_active |-> dcm_force && converter_run)
    else $error("start ramp not in discontinuous mode");
  load_dflt_a: assert property ($rose(host_access_en) |-> span_reg == rsc_pkg::SPAN_RST
    && ramp_reg == rsc_pkg::RAMP_RST && target_addr_code == $past(v_code, 2))
    else $error("defaults not loaded");
  dvs_step_a: assert property (cv_reg == CV_DVS && $changed(act_reg) |->
    (act_reg - $past(act_reg) == 8'h01) || ($past(act_reg) - act_reg == 8'h01))
    else $error("ramp step not one code");
  no_reload_a: assert property (init_done && supply_s |=> init_done)
    else $error("registers reloaded without supply loss");
endmodule : rsc_startup_ctrl

// ### tb/rsc_far_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// strap network and enable pull-up
// ----------------------------------------
module rsc_far_model (
  // strap setting, switches, enable request
  input wire logic [1:0] strap_set,
  input wire logic sw1,
  input wire logic sw2,
  input wire logic en_req,
  input wire logic en_oe,
  // resolved pin levels
  output logic pin,
  output logic en_pin
);
  // divider as seen through the bias switches; a resistor only moves the pin when a switch closes
  assign pin = strap_set[1] ? (strap_set[0] | ~sw2) : (strap_set[0] & sw1);
  // open-drain wire: the block's pull-down beats the host's pull-up
  assign en_pin = en_req & ~en_oe;
endmodule : rsc_far_model

// ### tb/tb_rsc_startup_ctrl.sv
`timescale 1ns/1ps
// ----------------------------------------
// start-up bench with queued expectations
// ----------------------------------------
module tb_rsc_startup_ctrl;
  logic clk = 0, resetn = 0, en_req = 0, wr_sp = 0, wr_sn = 0, wr_rp = 0, cko = 0, wsl = 0, sup = 1, flt = 0, sab = 0;
  logic [7:0] wd = 8'h00, spc, tlc;
  logic [1:0] vs = 2'h0, fs = 2'h0, spn, rmp, fsc, tac, slw;
  logic vp, fp, en_pin, eoe, v1, v2, f1, f2, hae, dcm, ssa, rac, cos;
  logic [29:0] exq[$];
  int failures = 0, cmp_count = 0, cyc = 0;
  event chk;
  always #4 clk = ~clk;
  rsc_far_model vm (.strap_set(vs), .sw1(v1), .sw2(v2), .en_req(en_req), .en_oe(eoe), .pin(vp), .en_pin(en_pin));
  rsc_far_model fm (.strap_set(fs), .sw1(f1), .sw2(f2), .en_req(1'b0), .en_oe(1'b0), .pin(fp), .en_pin());
  rsc_startup_ctrl #(.SS_CYC_0(20), .SS_CYC_1(40), .SS_CYC_2(80), .SS_CYC_3(160)) dut (.clk(clk), .resetn(resetn),
    .supply_ok(sup), .fault_present(flt), .standalone_bit(sab), .enable_in(en_pin), .enable_out(),
    .enable_oe(eoe), .voltage_strap(vp), .voltage_first_bias_switch(v1), .voltage_second_bias_switch(v2),
    .frequency_strap(fp), .frequency_first_bias_switch(f1), .frequency_second_bias_switch(f2),
    .clock_out_strap(cko), .wr_setpoint(wr_sp), .wr_span(wr_sn), .wr_ramp(wr_rp), .wr_slew(wsl),
    .wr_data(wd), .host_access_en(hae), .setpoint_code(spc), .output_span_code(spn),
    .ramp_duration_code(rmp), .slew_code(slw), .freq_sel_code(fsc), .freq_khz(), .target_addr_code(tac),
    .clock_out_sel(cos), .reference_en(), .converter_run(), .dcm_force(dcm), .soft_start_active(ssa),
    .ramp_active(rac), .target_level_code(tlc), .active_span_code(), .target_uv());
  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      failures++;
      stop_test();
    end
  end
  // monitor: oldest note against settled outputs
  always @(chk)
  begin : mon
    logic [29:0] e;
    #1;
    e = exq.pop_front();
    cmp_count++;
    if ({spc, spn, rmp, fsc, tac, tlc, dcm, ssa, eoe, cos, slw} !== e)
    begin
      failures++;
      $display("unexpected state exp %h got %h", e, {spc, spn, rmp, fsc, tac, tlc, dcm, ssa, eoe, cos, slw});
    end
  end
  task automatic note(input logic [29:0] e);
    exq.push_back(e);
    -> chk;
    @(posedge clk);
  endtask : note
  // wait on a level, checked off the sampling edge
  task automatic wait_on(input int k, input logic v);
    while ((k == 0 ? hae : k == 1 ? ssa : rac) !== v)
      @(negedge clk);
    @(posedge clk);
  endtask : wait_on
  // one-cycle strobe: 0 setpoint, 1 span, 2 ramp, 3 slew
  task automatic host_wr(input int s, input logic [7:0] d);
    wd <= d;
    wr_sp <= (s == 0);
    wr_sn <= (s == 1);
    wr_rp <= (s == 2);
    wsl <= (s == 3);
    @(posedge clk);
    {wr_sp, wr_sn, wr_rp, wsl} <= 4'h0;
    @(posedge clk);
  endtask : host_wr
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test
  initial
  begin
    void'($urandom(74));
    // every voltage strap code, random frequency strap
    for (int i = 0; i < 4; i++)
    begin
      resetn <= 1'b0;
      vs <= 2'(i);
      fs <= 2'($urandom_range(3));
      cko <= 1'($urandom_range(1));
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      wait_on(0, 1'b1);
      note({(i == 0) ? 8'h46 : (i == 3) ? 8'h5F : 8'h50, 2'h2, 2'h1, fs, vs, 8'h00, 2'h0, 1'b0, cko, 2'h0});
      $display("strap test %0d done", i);
    end
    // program while disabled: shortest ramp, new span, setpoint
    host_wr(2, 8'h00);
    host_wr(1, 8'h01);
    host_wr(0, 8'h30);
    host_wr(3, 8'h01);
    en_req <= 1'b1;
    wait_on(1, 1'b1);
    note({8'h30, 2'h1, 2'h0, fs, vs, 8'h30, 2'h3, 1'b0, cko, 2'h1});
    host_wr(0, 8'h31);
    note({8'h31, 2'h1, 2'h0, fs, vs, 8'h30, 2'h3, 1'b0, cko, 2'h1});
    wait_on(1, 1'b0);
    wait_on(2, 1'b0);
    note({8'h31, 2'h1, 2'h0, fs, vs, 8'h31, 2'h0, 1'b0, cko, 2'h1});
    $display("soft start test done");
    // toggle enable: nothing reloads
    en_req <= 1'b0;
    repeat (8) @(posedge clk);
    en_req <= 1'b1;
    wait_on(1, 1'b1);
    note({8'h31, 2'h1, 2'h0, fs, vs, 8'h31, 2'h3, 1'b0, cko, 2'h1});
    $display("toggle test done");
    // fault pulls enable low and stops the converter; standalone only frees the pin
    flt <= 1'b1;
    repeat (4) @(posedge clk);
    note({8'h31, 2'h1, 2'h0, fs, vs, 8'h31, 2'h0, 1'b1, cko, 2'h1});
    sab <= 1'b1;
    @(posedge clk);
    note({8'h31, 2'h1, 2'h0, fs, vs, 8'h31, 2'h0, 1'b0, cko, 2'h1});
    $display("fault test done");
    // supply loss: straps read again and defaults reloaded
    sup <= 1'b0;
    flt <= 1'b0;
    wait_on(0, 1'b0);
    sup <= 1'b1;
    wait_on(0, 1'b1);
    note({8'h5F, 2'h2, 2'h1, fs, vs, 8'h31, 2'h0, 1'b0, cko, 2'h0});
    $display("supply test done");
    stop_test();
  end
endmodule : tb_rsc_startup_ctrl
